// ### logic/gpio_irq_readback.sv
// Port A interrupt logic and pin readback, APB register slave
//
// Behaviour
// - Sensitivity bit: zero level, one edge
// - Polarity bit: zero low/falling, one high/rising
// - Masked status word readable, resets zero
// - Raw status word shows unmasked conditions
// - Filter enable bit removes glitches from source
// - Writing one clears latched edge interrupt
// - Port A readback: pins for inputs, data otherwise
// - Port B readback: pins for inputs, data otherwise
// - Sync bit routes levels through synchroniser
// - Sixteen-bit user identification word, read only
// - Version word encoded as ASCII characters
// - Build options report ident width minus one
// - Build options report include flags
// - Build options report single control flags
// - Interrupt enable gates a pin into detection
// - Mask bit one blocks interrupt output
// - Direction bit: zero input, one output
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "gpio_defines.svh"
module gpio_irq_readback #(
  parameter logic [15:0] USER_IDENT   = 16'h5A5A, // Arbitrary value
  parameter logic [31:0] VERSION_WORD = 32'h3130_3041, // Arbitrary value
  parameter logic        OPT_ENCODED  = 1'b1,
  parameter logic        OPT_HW_A     = 1'b0,
  parameter logic        OPT_HW_B     = 1'b0,
  parameter logic        OPT_SINGLE_A = 1'b1,
  parameter logic        OPT_SINGLE_B = 1'b1
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Port A pins and settings from the data registers
  input  wire gpio_pkg::port_a_type porta_pin_in,
  input  wire gpio_pkg::port_a_type porta_out_data,
  input  wire gpio_pkg::port_a_type porta_dir,
  // Port B pins and settings from the data registers
  input  wire gpio_pkg::port_b_type portb_pin_in,
  input  wire gpio_pkg::port_b_type portb_out_data,
  input  wire gpio_pkg::port_b_type portb_dir,
  // Interrupt to the controller
  output logic                    gpio_irq
);
  import gpio_pkg::*;

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  apb_phase_type            phase;
  port_a_type               irq_enable;
  port_a_type               irq_mask;
  port_a_type               irq_sens;
  port_a_type               irq_pol;
  port_a_type               filter_en;
  logic                     level_sync_select;
  port_a_type               irq_raw;
  port_a_type               irq_status;
  port_a_type               filtered;
  port_a_type               edge_clear;
  port_a_type               pa_readback;
  port_b_type               pb_readback;
  logic [`FILTER_CNT_W-1:0] filter_cnt;
  logic                     filter_tick;
  logic [31:0]              build_options_word;
  logic [4:0]               ident_width_minus_one;
  logic                     ident_present_flag;
  logic                     encoded_params_flag;
  logic                     first_port_hw_control_present;
  logic                     second_port_hw_control_present;
  logic                     setup;
  logic                     wr;
  logic [31:0]              next_prdata;
  logic                     next_pslverr;

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------

  // Setup cycle seen while idle; the answer follows one cycle later
  assign setup = psel & ~penable & (phase == PH_IDLE);
  // Writes land on the edge where the master samples pready high
  assign wr = psel & penable & pwrite & pready;

  // Phase of the slave: one cycle of answer per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
    end else begin
      unique case (phase)
        PH_IDLE: begin
          if (setup) phase <= PH_ANSWER;
        end
        PH_ANSWER: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // Handshake outputs come from flops; ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= next_pslverr;
      prdata  <= pwrite ? `RST_WORD : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end
  end

  // ----------------------------------------------------------
  // Control registers written by software
  // ----------------------------------------------------------

  // Enable and mask of each port A interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= `RST_PA;
      irq_mask   <= `RST_PA;
    end else if (wr) begin
      if (paddr == `OFS_IRQ_ENABLE)
        irq_enable <= pwdata[`PA_W-1:0];
      if (paddr == `OFS_IRQ_MASK)
        irq_mask <= pwdata[`PA_W-1:0];
    end
  end

  // Sensitivity and polarity of each port A interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sens <= `RST_PA;
      irq_pol  <= `RST_PA;
    end else if (wr) begin
      if (paddr == `OFS_IRQ_SENS)
        irq_sens <= pwdata[`PA_W-1:0];
      if (paddr == `OFS_IRQ_POL)
        irq_pol <= pwdata[`PA_W-1:0];
    end
  end

  // Glitch filter enables and the level synchronisation switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_en         <= `RST_PA;
      level_sync_select <= 1'b0;
    end else if (wr) begin
      if (paddr == `OFS_FILTER_EN)
        filter_en <= pwdata[`PA_W-1:0];
      if (paddr == `OFS_LEVEL_SYNC)
        level_sync_select <= pwdata[0];
    end
  end

  // Write-only clear: a one-cycle pulse, zeros leave flags alone
  assign edge_clear = (wr && paddr == `OFS_EDGE_CLEAR)
                    ? pwdata[`PA_W-1:0] : `RST_PA;

  // ----------------------------------------------------------
  // Glitch filter sample tick
  // ----------------------------------------------------------

  // Slow enable pulse; a glitch shorter than one period cannot pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_cnt  <= '0;
      filter_tick <= 1'b0;
    end else if (filter_cnt == `FILTER_CNT_W'(`FILTER_CYCLES - 1)) begin
      filter_cnt  <= '0;
      filter_tick <= 1'b1;
    end else begin
      filter_cnt  <= filter_cnt + 1'b1;
      filter_tick <= 1'b0;
    end
  end

  // Filter sits in front of detection so both levels and edges see it
  gpio_glitch_filter #(
    .WIDTH (`PA_W)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (filter_tick),
    .enable  (filter_en),
    .din     (porta_pin_in),
    .dout    (filtered)
  );

  // ----------------------------------------------------------
  // Interrupt detection and masking
  // ----------------------------------------------------------

  // Level or edge per pin, sense set by polarity
  gpio_irq_detect #(
    .WIDTH (`PA_W)
  ) u_detect (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (irq_enable),
    .edge_kind (irq_sens),
    .polarity  (irq_pol),
    .sync_sel  (level_sync_select),
    .src       (filtered),
    .clear     (edge_clear),
    .raw       (irq_raw)
  );

  // Masked status; the mask never hides the raw view
  assign irq_status = irq_raw & ~irq_mask;

  // Single level interrupt, high while any unmasked bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gpio_irq <= 1'b0;
    else
      gpio_irq <= |irq_status;
  end

  // ----------------------------------------------------------
  // Pin readback
  // ----------------------------------------------------------

  // Outputs read back the driven data, inputs read the pin itself
  assign pa_readback = (porta_dir & porta_out_data)
                     | (~porta_dir & porta_pin_in);
  assign pb_readback = (portb_dir & portb_out_data)
                     | (~portb_dir & portb_pin_in);

  // ----------------------------------------------------------
  // Identification and build options
  // ----------------------------------------------------------

  assign ident_width_minus_one = 5'(`IDENT_WIDTH - 1);
  assign ident_present_flag             = 1'b1;
  assign encoded_params_flag            = OPT_ENCODED;
  assign first_port_hw_control_present  = OPT_HW_A;
  assign second_port_hw_control_present = OPT_HW_B;

  // Fixed at build time; unlisted bits read as zero
  always_comb begin
    build_options_word = `RST_WORD;
    build_options_word[`BO_IDW_LSB +: 5] = ident_width_minus_one;
    build_options_word[`BO_IDENT_BIT] = ident_present_flag;
    build_options_word[`BO_ENC_BIT]   = encoded_params_flag;
    build_options_word[`BO_DEB_BIT]   = 1'b1;
    build_options_word[`BO_PAIRQ_BIT] = 1'b1;
    build_options_word[`BO_HWB_BIT]   = second_port_hw_control_present;
    build_options_word[`BO_HWA_BIT]   = first_port_hw_control_present;
    build_options_word[`BO_SCB_BIT]   = OPT_SINGLE_B;
    build_options_word[`BO_SCA_BIT]   = OPT_SINGLE_A;
  end

  // ----------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------

  // Unmapped offsets answer zero with an error; the clear reads zero
  always_comb begin
    next_prdata  = `RST_WORD;
    next_pslverr = 1'b0;
    case (paddr)
      `OFS_IRQ_ENABLE:  next_prdata[`PA_W-1:0] = irq_enable;
      `OFS_IRQ_MASK:    next_prdata[`PA_W-1:0] = irq_mask;
      `OFS_IRQ_SENS:    next_prdata[`PA_W-1:0] = irq_sens;
      `OFS_IRQ_POL:     next_prdata[`PA_W-1:0] = irq_pol;
      `OFS_IRQ_STATUS:  next_prdata[`PA_W-1:0] = irq_status;
      `OFS_IRQ_RAW:     next_prdata[`PA_W-1:0] = irq_raw;
      `OFS_FILTER_EN:   next_prdata[`PA_W-1:0] = filter_en;
      `OFS_EDGE_CLEAR:  next_prdata = `RST_WORD;
      `OFS_PA_READBACK: next_prdata[`PA_W-1:0] = pa_readback;
      `OFS_PB_READBACK: next_prdata[`PB_W-1:0] = pb_readback;
      `OFS_LEVEL_SYNC:  next_prdata[0] = level_sync_select;
      `OFS_IDENT:       next_prdata[15:0] = USER_IDENT;
      `OFS_VERSION:     next_prdata = VERSION_WORD;
      `OFS_BUILD_OPT:   next_prdata = build_options_word;
      default:          next_pslverr = 1'b1;
    endcase
  end

endmodule : gpio_irq_readback

// ### logic/gpio_defines.svh
// Constants for the port A interrupt and pin readback block
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ----------------------------------------------------------
// Port widths
// ----------------------------------------------------------
`define PA_W              18
`define PB_W              17

// ----------------------------------------------------------
// Register byte offsets (low address byte only)
// ----------------------------------------------------------
`define OFS_IRQ_ENABLE    8'h30
`define OFS_IRQ_MASK      8'h34
`define OFS_IRQ_SENS      8'h38
`define OFS_IRQ_POL       8'h3C
`define OFS_IRQ_STATUS    8'h40
`define OFS_IRQ_RAW       8'h44
`define OFS_FILTER_EN     8'h48
`define OFS_EDGE_CLEAR    8'h4C
`define OFS_PA_READBACK   8'h50
`define OFS_PB_READBACK   8'h54
`define OFS_LEVEL_SYNC    8'h60
`define OFS_IDENT         8'h64
`define OFS_VERSION       8'h6C
`define OFS_BUILD_OPT     8'h74

// ----------------------------------------------------------
// Reset values and field layout of the build options word
// ----------------------------------------------------------
`define RST_PA            18'h0_0000
`define RST_WORD          32'h0000_0000
`define IDENT_WIDTH       16
`define BO_IDW_LSB        16
`define BO_IDENT_BIT      15
`define BO_ENC_BIT        14
`define BO_DEB_BIT        13
`define BO_PAIRQ_BIT      12
`define BO_HWB_BIT        9
`define BO_HWA_BIT        8
`define BO_SCB_BIT        5
`define BO_SCA_BIT        4

// ----------------------------------------------------------
// Timing: glitch filter sample period
// ----------------------------------------------------------
`define CLK_PERIOD_NS     5
`define FILTER_TIME_NS    1000
`define FILTER_CYCLES     ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CNT_W      8

`endif

// ### logic/gpio_pkg.sv
// Types shared by the port A interrupt and readback block
package gpio_pkg;
  typedef logic [17:0] port_a_type;
  typedef logic [16:0] port_b_type;
  // APB slave phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_ANSWER = 2'b10
  } apb_phase_type;
endpackage : gpio_pkg

// ### logic/gpio_glitch_filter.sv
// Per-pin glitch filter sampled on a slow enable pulse
`timescale 1ns/1ps
module gpio_glitch_filter #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] enable,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] sample;
  logic [WIDTH-1:0] held;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A level passes only after two agreeing samples one tick apart
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sample[i] <= 1'b0;
          held[i]   <= 1'b0;
        end else if (tick) begin
          sample[i] <= din[i];
          if (sample[i] == din[i]) held[i] <= din[i];
        end
      end
      // Bypass when filtering is off for this pin
      assign dout[i] = enable[i] ? held[i] : din[i];
    end
  endgenerate
endmodule : gpio_glitch_filter

// ### logic/gpio_irq_detect.sv
// Per-pin level or edge interrupt detection for port A
`timescale 1ns/1ps
module gpio_irq_detect #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Configuration
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] edge_kind,
  input  wire logic [WIDTH-1:0] polarity,
  input  wire logic             sync_sel,
  // Source and clear
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] clear,
  // Result
  output logic      [WIDTH-1:0] raw
);
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] edge_flag;
  logic [WIDTH-1:0] active;
  logic [WIDTH-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign active[i] = polarity[i] ? src[i] : ~src[i];
      assign hit[i] = polarity[i] ? (src[i] & ~prev[i])
                                  : (~src[i] & prev[i]);
      // Previous value and two-stage level synchroniser
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev[i]  <= 1'b0;
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
        end else begin
          prev[i]  <= src[i];
          sync1[i] <= active[i];
          sync2[i] <= sync1[i];
        end
      end
      // Sticky edge flag; a new edge wins over a clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          edge_flag[i] <= 1'b0;
        else if (enable[i] & edge_kind[i] & hit[i])
          edge_flag[i] <= 1'b1;
        else if (clear[i])
          edge_flag[i] <= 1'b0;
      end
      // Level follows the pin; edge holds until cleared
      assign raw[i] = enable[i] & (edge_kind[i] ? edge_flag[i]
                    : (sync_sel ? sync2[i] : active[i]));
    end
  endgenerate
endmodule : gpio_irq_detect

// ### test/gpio_irq_readback_sva.sv
// Checker for the register side of the interrupt and readback block
`timescale 1ns/1ps
module gpio_irq_readback_sva #(
  parameter logic [15:0] USER_IDENT   = 16'h0000,
  parameter logic [31:0] VERSION_WORD = 32'h0000_0000,
  parameter logic        OPT_ENCODED  = 1'b1,
  parameter logic        OPT_HW_A     = 1'b0,
  parameter logic        OPT_HW_B     = 1'b0,
  parameter logic        OPT_SINGLE_A = 1'b1,
  parameter logic        OPT_SINGLE_B = 1'b1
) (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Pins
  input wire gpio_pkg::port_a_type porta_pin_in,
  input wire gpio_pkg::port_a_type porta_out_data,
  input wire gpio_pkg::port_a_type porta_dir,
  input wire gpio_pkg::port_b_type portb_pin_in,
  input wire gpio_pkg::port_b_type portb_out_data,
  input wire gpio_pkg::port_b_type portb_dir,
  // Interrupt
  input wire logic                 gpio_irq
);
  import gpio_pkg::*;
  localparam logic [31:0] BUILD = {11'h0, 5'h0F, 1'b1, OPT_ENCODED, 2'h3,
    2'h0, OPT_HW_B, OPT_HW_A, 2'h0, OPT_SINGLE_B, OPT_SINGLE_A, 4'h0};
  logic       rd;
  logic       mapped;
  port_a_type exp_a;
  port_b_type exp_b;
  // Read data is latched at the setup edge, so compare with last cycle
  assign rd     = pready && !pwrite;
  assign mapped = paddr inside {8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44,
    8'h48, 8'h4C, 8'h50, 8'h54, 8'h60, 8'h64, 8'h6C, 8'h74};
  assign exp_a  = (porta_pin_in & ~porta_dir) | (porta_out_data & porta_dir);
  assign exp_b  = (portb_pin_in & ~portb_dir) | (portb_out_data & portb_dir);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_readback_a: assert property (rd && paddr == 8'h50
    |-> prdata == {14'h0, $past(exp_a)}) else $error("port A readback");
  chk_readback_b: assert property (rd && paddr == 8'h54
    |-> prdata == {15'h0, $past(exp_b)}) else $error("port B readback");
  chk_ident_read: assert property (rd && paddr == 8'h64
    |-> prdata == {16'h0, USER_IDENT}) else $error("ident word");
  chk_version_read: assert property (rd && paddr == 8'h6C
    |-> prdata == VERSION_WORD) else $error("version word");
  chk_build_opts: assert property (rd && paddr == 8'h74
    |-> prdata == BUILD) else $error("build options word");
  // Main traffic kinds
  cover property (rd && paddr == 8'h44);
  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property ($rose(gpio_irq));
endmodule : gpio_irq_readback_sva

bind gpio_irq_readback gpio_irq_readback_sva #(
  .USER_IDENT(USER_IDENT), .VERSION_WORD(VERSION_WORD),
  .OPT_ENCODED(OPT_ENCODED), .OPT_HW_A(OPT_HW_A), .OPT_HW_B(OPT_HW_B),
  .OPT_SINGLE_A(OPT_SINGLE_A), .OPT_SINGLE_B(OPT_SINGLE_B)
) i_gpio_irq_readback_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .porta_pin_in(porta_pin_in),
  .porta_out_data(porta_out_data), .porta_dir(porta_dir),
  .portb_pin_in(portb_pin_in), .portb_out_data(portb_out_data),
  .portb_dir(portb_dir), .gpio_irq(gpio_irq)
);

// ### test/gpio_pad_model.sv
// Off-chip pad model feeding the pin inputs of one port
`timescale 1ns/1ps
module gpio_pad_model #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Level applied off chip and pin direction
  input  wire logic [WIDTH-1:0] ext_level,
  input  wire logic [WIDTH-1:0] dir,
  // Pin as seen by the block
  output logic      [WIDTH-1:0] pin
);
  logic [WIDTH-1:0] scramble;
  // Flips every cycle so a stale pin value can never pass for a match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scramble <= '0;
    end else begin
      scramble <= ~scramble;
    end
  end
  // Output bits carry no off-chip level
  assign pin = (ext_level & ~dir) | (scramble & dir);
endmodule : gpio_pad_model

// ### test/gpio_irq_readback_tb.sv
// Self-checking bench for the interrupt and readback block
`timescale 1ns/1ps
module gpio_irq_readback_tb;
  import gpio_pkg::*;
  localparam logic [15:0] IDENT = 16'hC3A5; // Arbitrary value
  localparam logic [31:0] VER   = 32'h3032_3135; // Arbitrary value
  localparam logic [31:0] BUILD = 32'h000F_F030;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, gpio_irq;
  port_a_type  ext_a = '0, a_out = '0, a_dir = '0, pin_a;
  port_b_type  ext_b = '0, b_out = '0, b_dir = '0, pin_b;
  int          fail_count = 0;
  int          comparisons = 0;

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  gpio_irq_readback #(.USER_IDENT(IDENT), .VERSION_WORD(VER)) i_gpio_irq_readback (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .porta_pin_in(pin_a),
    .porta_out_data(a_out), .porta_dir(a_dir), .portb_pin_in(pin_b),
    .portb_out_data(b_out), .portb_dir(b_dir), .gpio_irq(gpio_irq));
  gpio_pad_model #(.WIDTH(18)) i_gpio_pad_model_a (.pclk(pclk),
    .presetn(presetn), .ext_level(ext_a), .dir(a_dir), .pin(pin_a));
  gpio_pad_model #(.WIDTH(17)) i_gpio_pad_model_b (.pclk(pclk),
    .presetn(presetn), .ext_level(ext_b), .dir(b_dir), .pin(pin_b));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for ready however long it takes; only the watchdog ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [32:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, {1'b0, exp});
  endtask : rd

  // Pins take a value just after the edge, then wait
  task automatic pins(input port_a_type v, input int cyc);
    ext_a <= v;
    repeat (cyc) @(posedge pclk);
  endtask : pins

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset_values;
    logic [7:0]  offs [11] = '{8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44,
                               8'h48, 8'h4C, 8'h50, 8'h54, 8'h60};
    logic [32:0] q;
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(8'h64, {16'h0, IDENT});
    rd(8'h6C, VER);
    rd(8'h74, BUILD);
    apb(1'b0, 8'h58, 32'h0, q);
    check(q, {1'b1, 32'h0});
    $display("test reset_values done");
  endtask : t_reset_values

  // Enable goes last on the way up, first on the way down
  task automatic t_access;
    logic [7:0]  offs [6] = '{8'h34, 8'h38, 8'h3C, 8'h48, 8'h60, 8'h30};
    logic [31:0] msk  [6] = '{32'h3_FFFF, 32'h3_FFFF, 32'h3_FFFF,
                              32'h3_FFFF, 32'h1, 32'h3_FFFF};
    foreach (offs[i]) wr(offs[i], 32'hFFFF_FFFF);
    foreach (offs[i]) rd(offs[i], msk[i]);
    wr(8'h44, 32'hFFFF_FFFF);
    wr(8'h64, 32'hFFFF_FFFF);
    rd(8'h44, 32'h0);
    rd(8'h64, {16'h0, IDENT});
    for (int i = 5; i >= 0; i--) wr(offs[i], 32'h0);
    $display("test access done");
  endtask : t_access

  task automatic t_readback;
    ext_a <= 18'h2_A5C3;
    a_dir <= 18'h0_FF00;
    a_out <= 18'h1_5A5A;
    ext_b <= 17'h1_3C3C;
    b_dir <= 17'h0_0F0F;
    b_out <= 17'h0_A5A5;
    rd(8'h50, {14'h0, 18'h2_A5C3 & ~18'h0_FF00 | 18'h0_5A00});
    rd(8'h54, {15'h0, 17'h1_3C3C & ~17'h0_0F0F | 17'h0_0505});
    a_dir <= '0;
    b_dir <= '0;
    ext_b <= '0;
    pins('0, 1);
    $display("test readback done");
  endtask : t_readback

  // Bit 3 rising edge, bit 5 falling edge
  task automatic t_edge;
    pins(18'h0_0020, 4);
    wr(8'h38, 32'h28);
    wr(8'h3C, 32'h08);
    wr(8'h30, 32'h28);
    pins(18'h0_0008, 4);
    rd(8'h44, 32'h28);
    rd(8'h40, 32'h28);
    check({32'h0, gpio_irq}, 33'h1);
    pins(18'h0_0020, 4);
    wr(8'h4C, 32'h0);
    rd(8'h44, 32'h28);
    wr(8'h4C, 32'h08);
    rd(8'h44, 32'h20);
    wr(8'h34, 32'h20);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h20);
    check({32'h0, gpio_irq}, 33'h0);
    wr(8'h30, 32'h0);
    wr(8'h4C, 32'h20);
    wr(8'h34, 32'h0);
    pins('0, 2);
    $display("test edge done");
  endtask : t_edge

  // Bit 7 level; sync delays a level by two cycles
  task automatic t_level;
    wr(8'h30, 32'h80);
    rd(8'h44, 32'h80);
    check({32'h0, gpio_irq}, 33'h1);
    pins(18'h0_0080, 0);
    rd(8'h44, 32'h0);
    wr(8'h3C, 32'h80);
    wr(8'h60, 32'h1);
    pins('0, 0);
    rd(8'h44, 32'h80);
    rd(8'h44, 32'h0);
    wr(8'h30, 32'h0);
    wr(8'h3C, 32'h0);
    wr(8'h60, 32'h0);
    $display("test level done");
  endtask : t_level

  // Bit 9 filtered, bit 10 not; filter needs two slow samples
  task automatic t_filter;
    wr(8'h48, 32'h200);
    wr(8'h38, 32'h600);
    wr(8'h3C, 32'h600);
    wr(8'h30, 32'h600);
    pins(18'h0_0600, 10);
    pins('0, 900);
    rd(8'h44, 32'h400);
    pins(18'h0_0200, 900);
    rd(8'h44, 32'h600);
    wr(8'h30, 32'h0);
    wr(8'h4C, 32'h600);
    pins('0, 900);
    $display("test filter done");
  endtask : t_filter

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_values();
    t_access();
    t_readback();
    t_edge();
    t_level();
    t_filter();
    results();
  end

  // Tests need about 3000 cycles; allow far more before giving up
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule : gpio_irq_readback_tb
